// ===== logic/ppd_pixel_pipe.sv
// Pixel pipeline datapath: lanes, shifters, delay, selector, mask, clip, assembler
// Contract
// [RL1] All pipeline data paths are 64 bits wide.
// [RL2] Input synchronised and laned by tap format; no user control.
// [RL3] Four 16-bit shifters share one shift command.
// [RL4] Command gives left/right and amount 0 to 15.
// [RL5] Handles up to four taps so deep pixels reduce to 8 bits.
// [RL6] Video delay of 0 to 8 pixel clocks.
// [RL7] Selector chooses camera or synthetic test video.
// [RL8] One 32-bit mask applied to both halves.
// [RL9] Mask one passes bit, zero clears it.
// [RL10] Clip acts on each of eight 8-bit lanes.
// [RL11] Lanes above 245 become 245, below 10 become 10.
// [RL12] Assembler emits pixels in raster order.
// [RL13] Packing follows pixel depth field.
// [RL14] Eight-bit view packs all pixels as 8 bits; code takes each 16-bit slice's low byte, two per 32-bit pixel.
// [RL15] Software right-shifts by excess depth when eight-bit view used.
// [RL16] Lane exchange swaps odd and even pixel streams.
// [RL17] FIFO writes only inside the acquisition window.
// [RL18] Readable format code identifies loaded tap-format variant.
// [RL19] Active-clocks count is 17 bits, clocks per active line.
// [RL20] Stages chained in order, registered, valid carried along.
// [RL21] Reset: no shift, no delay, camera, mask ones, features off.
//
// Chosen here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "ppd_consts.svh"
module ppd_pixel_pipe
#(
  parameter logic [4:0] FORMAT_CODE = 5'h01,  // Odd-even two tap variant
  parameter int         TAPS        = 2
)
(
  input  wire logic         sys_clk,
  input  wire logic         resetn,
  // Camera side (asynchronous pins)
  input  wire logic [63:0]  camData,
  input  wire logic         camValid,
  input  wire logic         lineStart,
  input  wire logic         frameStart,
  // FIFO side
  output logic      [63:0]  fifoData,
  output logic              fifoWrite,
  // AXI4-Lite slave
  input  wire logic [7:0]   s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  input  wire logic [7:0]   s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready
);

  //----------------------------------------------------------------
  // State
  //----------------------------------------------------------------
  typedef struct packed
  {
    logic [63:0]            sy1Data;
    logic [2:0]             sy1Ctl;
    logic [63:0]            sy2Data;
    logic [2:0]             sy2Ctl;
    logic                   lsPrev;
    logic                   fsPrev;
    ppd_pkg::ppd_beat_t     lane;
    logic [8:0]             shVld;
    logic [7:0][63:0]       dly;
    ppd_pkg::ppd_beat_t     sel;
    ppd_pkg::ppd_beat_t     msk;
    ppd_pkg::ppd_beat_t     clp;
    logic [63:0]            asmAcc;
    logic                   asmHalf;
    logic [63:0]            outData;
    logic                   outWr;
    logic [16:0]            hCnt;
    logic [16:0]            vCnt;
    logic                   inLine;
    logic [7:0]             patCnt;
    logic [31:0]            ctrl;
    logic [31:0]            mask;
    logic [16:0]            aclk;
    logic [16:0]            alin;
    logic                   awHeld;
    logic [7:0]             awAddr;
    logic                   wHeld;
    logic [31:0]            wData;
    logic [3:0]             wStrb;
    logic                   bValid;
    logic [1:0]             bResp;
    logic                   rValid;
    logic [31:0]            rData;
    logic [1:0]             rResp;
  } ppd_st_t;

  ppd_st_t st_q, st_d;
  ppd_shift_if shCmd();
  logic [63:0] shOut;

  //----------------------------------------------------------------
  // Shifter lanes
  //----------------------------------------------------------------
  // Shared command straight from the control register
  assign shCmd.shRight = st_q.ctrl[`PPD_CTRL_SHDIR];
  assign shCmd.shAmt   = st_q.ctrl[`PPD_CTRL_SHAMT];

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : gShift
      ppd_shift16 uSh
      (
        .sysClk (sys_clk),
        .resetn (resetn),
        .cmd    (shCmd),
        .dIn    (st_q.lane.data[g*16 +: 16]),
        .dOut   (shOut[g*16 +: 16])
      ); // [RL3] [RL5]
    end
  endgenerate

  // Byte-wise write with strobes
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (sb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction

  //----------------------------------------------------------------
  // Next state
  //----------------------------------------------------------------
  always_comb
  begin
    logic [63:0] lanes;
    logic [63:0] src;
    logic [63:0] m;
    logic [3:0]  dsel;
    logic [7:0]  b;
    logic        inWin;
    logic        lsRise;
    logic        fsRise;
    logic [31:0] rd;
    logic [7:0]  wa;
    lanes = '0; src = '0; m = '0; dsel = '0; b = '0; inWin = 1'b0;
    lsRise = 1'b0; fsRise = 1'b0; rd = '0; wa = '0;
    st_d = st_q;

    // Pins pass two flops before use
    st_d.sy1Data = camData;
    st_d.sy1Ctl  = {frameStart, lineStart, camValid};
    st_d.sy2Data = st_q.sy1Data;
    st_d.sy2Ctl  = st_q.sy1Ctl; // [RL2]
    st_d.lsPrev  = st_q.sy2Ctl[1];
    st_d.fsPrev  = st_q.sy2Ctl[2];
    lsRise = st_q.sy2Ctl[1] & ~st_q.lsPrev;
    fsRise = st_q.sy2Ctl[2] & ~st_q.fsPrev;

    // Lane assignment fixed by the loaded format; exchange flips odd/even words
    lanes = st_q.sy2Data;
    if (TAPS == 2 && st_q.ctrl[`PPD_CTRL_SWAP])
      lanes = {st_q.sy2Data[31:0], st_q.sy2Data[63:32]}; // [RL16]
    st_d.lane.data  = lanes; // [RL1] [RL2]
    st_d.lane.valid = st_q.sy2Ctl[0];

    // Valid rides its own chain so every delay tap keeps data and flag paired
    st_d.shVld = {st_q.shVld[7:0], st_q.lane.valid};
    st_d.dly[0] = shOut;
    for (int i = 1; i < 8; i++)
      st_d.dly[i] = st_q.dly[i-1];
    dsel = st_q.ctrl[`PPD_CTRL_DELAY];
    if (dsel > `PPD_DELAY_MAX) dsel = `PPD_DELAY_MAX; // [RL6]

    // Synthetic pattern (ramp, toggle, fixed bytes or alternating) or camera video
    st_d.patCnt = st_q.patCnt + 8'h01;
    unique case (st_q.ctrl[`PPD_CTRL_PATSEL])
      2'h0:    src = {8{st_q.patCnt}};
      2'h1:    src = {8{st_q.patCnt[0] ? 8'hFF : 8'h00}};
      2'h2:    src = 64'h0706_0504_0302_0100;
      default: src = 64'hAAAA_AAAA_5555_5555;
    endcase
    // Tap zero is the shifter output itself, so a delay of n costs n clocks
    lanes = (dsel == 4'h0) ? shOut : st_q.dly[dsel - 4'h1]; // [RL6]
    st_d.sel.data  = st_q.ctrl[`PPD_CTRL_SYNSEL] ? src : lanes; // [RL7] [RL20]
    st_d.sel.valid = st_q.ctrl[`PPD_CTRL_SYNSEL] ? 1'b1 : st_q.shVld[dsel];

    // Mask replicated over both halves
    st_d.msk.data  = st_q.sel.data & {st_q.mask, st_q.mask}; // [RL8] [RL9]
    st_d.msk.valid = st_q.sel.valid;

    // Per-lane clip
    for (int i = 0; i < 8; i++)
    begin
      b = st_q.msk.data[i*8 +: 8];
      if (st_q.ctrl[`PPD_CTRL_CLIPEN])
      begin
        if (b > `PPD_CLIP_HI) b = `PPD_CLIP_HI;
        else if (b < `PPD_CLIP_LO) b = `PPD_CLIP_LO; // [RL10] [RL11]
      end
      m[i*8 +: 8] = b;
    end
    st_d.clp.data  = m;
    st_d.clp.valid = st_q.msk.valid;

    // Window: lines from frame start, clocks from line start; counting one line
    // past the last active one is what closes the window vertically
    if (fsRise) st_d.vCnt = '0;
    else if (lsRise && st_q.vCnt <= st_q.alin && st_q.vCnt != 17'h1FFFF)
      st_d.vCnt = st_q.vCnt + 17'h1;
    if (lsRise)
    begin
      st_d.hCnt = '0;
      st_d.inLine = 1'b1;
    end
    else if (st_q.clp.valid && st_q.inLine)
      st_d.hCnt = st_q.hCnt + 17'h1; // [RL19]
    inWin = st_q.inLine && st_q.hCnt < st_q.aclk && st_q.vCnt != 17'h0
            && st_q.vCnt <= st_q.alin; // [RL17]

    // Assembler: raster order, pack by depth or force 8-bit view
    st_d.outWr = 1'b0;
    if (st_q.clp.valid && inWin)
    begin
      if (st_q.ctrl[`PPD_CTRL_VIEW8] &&
          st_q.ctrl[`PPD_CTRL_DEPTH] != ppd_pkg::PPD_D8)
      begin
        // Low byte of each 16-bit slice, two beats make one word
        for (int i = 0; i < 4; i++)
          m[i*8 +: 8] = st_q.clp.data[i*16 +: 8]; // [RL14] [RL15]
        if (st_q.asmHalf)
        begin
          st_d.outData = {m[31:0], st_q.asmAcc[31:0]}; // [RL12]
          st_d.outWr   = 1'b1;
        end
        st_d.asmAcc  = {32'h0, m[31:0]};
        st_d.asmHalf = ~st_q.asmHalf;
      end
      else
      begin
        st_d.outData = st_q.clp.data; // [RL13]
        st_d.outWr   = 1'b1;
      end
    end

    // AXI4-Lite write: address and data in any order
    if (s_axi_awvalid && !st_q.awHeld)
    begin
      st_d.awHeld = 1'b1;
      st_d.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_q.wHeld)
    begin
      st_d.wHeld = 1'b1;
      st_d.wData = s_axi_wdata;
      st_d.wStrb = s_axi_wstrb;
    end
    if (st_q.awHeld && st_q.wHeld && !st_q.bValid)
    begin
      st_d.awHeld = 1'b0;
      st_d.wHeld  = 1'b0;
      st_d.bValid = 1'b1;
      st_d.bResp  = 2'h0;
      wa = {st_q.awAddr[7:2], 2'b00};
      unique case (wa)
        `PPD_REG_CTRL: st_d.ctrl = wmerge(st_q.ctrl, st_q.wData, st_q.wStrb);
        `PPD_REG_MASK: st_d.mask = wmerge(st_q.mask, st_q.wData, st_q.wStrb);
        `PPD_REG_ACLK: st_d.aclk = 17'(wmerge({15'h0, st_q.aclk}, st_q.wData, st_q.wStrb));
        `PPD_REG_ALIN: st_d.alin = 17'(wmerge({15'h0, st_q.alin}, st_q.wData, st_q.wStrb));
        `PPD_REG_STAT: st_d.bResp = 2'h0;
        default:       st_d.bResp = 2'h2;
      endcase
    end
    if (st_q.bValid && s_axi_bready) st_d.bValid = 1'b0;

    // AXI4-Lite read
    if (s_axi_arvalid && !st_q.rValid)
    begin
      st_d.rValid = 1'b1;
      st_d.rResp  = 2'h0;
      unique case ({s_axi_araddr[7:2], 2'b00})
        `PPD_REG_CTRL: rd = st_q.ctrl;
        `PPD_REG_MASK: rd = st_q.mask;
        `PPD_REG_ACLK: rd = {15'h0, st_q.aclk};
        `PPD_REG_ALIN: rd = {15'h0, st_q.alin};
        `PPD_REG_STAT:
        begin
          rd[`PPD_STAT_FMT] = FORMAT_CODE; // [RL18]
          rd[`PPD_STAT_VAL] = inWin;
        end
        default: st_d.rResp = 2'h2;
      endcase
      st_d.rData = rd;
    end
    else if (st_q.rValid && s_axi_rready)
      st_d.rValid = 1'b0;
  end

  //----------------------------------------------------------------
  // Registers
  //----------------------------------------------------------------
  // Control defaults give a transparent pipe on camera video
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_q      <= '0;
      st_q.ctrl <= `PPD_CTRL_RST; // [RL21]
      st_q.mask <= `PPD_MASK_RST;
    end
    else
      st_q <= st_d;
  end

  //----------------------------------------------------------------
  // Outputs
  //----------------------------------------------------------------
  assign fifoData      = st_q.outData;
  assign fifoWrite     = st_q.outWr;
  assign s_axi_awready = ~st_q.awHeld;
  assign s_axi_wready  = ~st_q.wHeld;
  assign s_axi_bvalid  = st_q.bValid;
  assign s_axi_bresp   = st_q.bResp;
  assign s_axi_arready = ~st_q.rValid;
  assign s_axi_rvalid  = st_q.rValid;
  assign s_axi_rdata   = st_q.rData;
  assign s_axi_rresp   = st_q.rResp;
endmodule // ppd_pixel_pipe

// ===== logic/ppd_consts.svh
// Register offsets, field positions, reset values and stage constants for the pixel pipeline
`ifndef PPD_CONSTS_SVH
`define PPD_CONSTS_SVH
`define PPD_REG_CTRL     8'h00
`define PPD_REG_MASK     8'h04
`define PPD_REG_ACLK     8'h08
`define PPD_REG_ALIN     8'h0C
`define PPD_REG_STAT     8'h10
`define PPD_CTRL_SHAMT   3:0
`define PPD_CTRL_SHDIR   4
`define PPD_CTRL_DELAY   8:5
`define PPD_CTRL_SYNSEL  9
`define PPD_CTRL_CLIPEN  10
`define PPD_CTRL_SWAP    11
`define PPD_CTRL_VIEW8   12
`define PPD_CTRL_DEPTH   14:13
`define PPD_CTRL_PATSEL  16:15
`define PPD_CTRL_RST     32'h0000_0000
`define PPD_MASK_RST     32'hFFFF_FFFF
`define PPD_CLIP_HI      8'hF5
`define PPD_CLIP_LO      8'h0A
`define PPD_DELAY_MAX    4'h8
`define PPD_STAT_FMT     4:0
`define PPD_STAT_VAL     5
`endif

// ===== logic/ppd_pkg.sv
// Types shared by the pixel pipeline modules
package ppd_pkg;
  typedef enum logic [1:0] {PPD_D8 = 2'h0, PPD_D16 = 2'h1, PPD_D32 = 2'h2} ppd_depth_t;
  typedef struct packed
  {
    logic [63:0] data;
    logic        valid;
  } ppd_beat_t;
endpackage

// ===== logic/ppd_shift_if.sv
// Shift command carried from the top to the shifter stage
`timescale 1ns/1ps
interface ppd_shift_if;
  logic        shRight;
  logic [3:0]  shAmt;
  modport ctl (output shRight, output shAmt);
  modport sh  (input shRight, input shAmt);
endinterface

// ===== logic/ppd_shift16.sv
// One 16-bit barrel shifter lane, registered
`timescale 1ns/1ps
module ppd_shift16
(
  input  wire logic         sysClk,
  input  wire logic         resetn,
  ppd_shift_if.sh           cmd,
  input  wire logic [15:0]  dIn,
  output logic      [15:0]  dOut
);
  typedef struct packed { logic [15:0] d; } ppd_sh_st_t;
  ppd_sh_st_t st_q, st_d;

  // Direction and amount shared by every lane
  always_comb
  begin
    st_d = st_q;
    st_d.d = cmd.shRight ? (dIn >> cmd.shAmt) : (dIn << cmd.shAmt); // [RL4]
  end

  always_ff @(posedge sysClk or negedge resetn)
  begin
    if (!resetn) st_q <= '0;
    else         st_q <= st_d;
  end
  assign dOut = st_q.d;
endmodule // ppd_shift16

// ===== bench/ppd_pipe_monitor.sv
// Bus and stream checker bound to the pixel pipeline top
`timescale 1ns/1ps
`include "ppd_consts.svh"
module ppd_pipe_monitor
#(
  parameter logic [4:0] FORMAT_CODE = 5'h01
)
(
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic        camValid,
  input wire logic        fifoWrite,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic [7:0] rdAddr_q;
  logic [4:0] idle_q;
  logic       mapped;
  // ----------------------------------------
  // Helper state
  // ----------------------------------------
  // Read address and idle time; saturating so a long gap never wraps
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
    begin
      rdAddr_q <= 8'h00;
      idle_q   <= 5'h00;
    end
    else
    begin
      if (s_axi_arvalid && s_axi_arready) rdAddr_q <= s_axi_araddr;
      if (camValid) idle_q <= 5'h00;
      else if (idle_q != 5'h1F) idle_q <= idle_q + 5'h01;
    end
  // Byte lanes within a word decode to that word's register
  assign mapped = (rdAddr_q <= (`PPD_REG_STAT | 8'h03));
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address open during response");
  AST_AW_BLOCK: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("write address open while one is held");
  AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read not answered");
  AST_B_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:3] s_axi_bvalid) else $error("write not answered");
  AST_R_RESP: assert property (s_axi_rvalid |-> s_axi_rresp == (mapped ? 2'h0 : 2'h2))
    else $error("wrong read response code");
  AST_STAT_FORMAT: assert property (s_axi_rvalid && rdAddr_q == `PPD_REG_STAT
    |-> s_axi_rdata[4:0] == FORMAT_CODE) else $error("wrong format code");
  AST_IDLE_QUIET: assert property (idle_q == 5'h1F |-> !fifoWrite)
    else $error("fifo write with no camera data");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (fifoWrite);
endmodule // ppd_pipe_monitor

bind ppd_pixel_pipe ppd_pipe_monitor #(.FORMAT_CODE(FORMAT_CODE)) u_ppd_pipe_monitor
  (.sys_clk, .resetn, .camValid, .fifoWrite, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// ===== bench/ppd_cam_model.sv
// Camera receiver and capture fifo model
`timescale 1ns/1ps
module ppd_cam_model
(
  input  wire logic        sys_clk,
  output logic      [63:0] camData,
  output logic             camValid,
  output logic             lineStart,
  output logic             frameStart,
  input  wire logic [63:0] fifoData,
  input  wire logic        fifoWrite
);
  logic [63:0] got[$];
  initial
  begin
    camData = 64'h0;
    camValid = 1'b0;
    lineStart = 1'b0;
    frameStart = 1'b0;
  end
  // Fifo side accepts every word at once, like an empty capture fifo
  always @(posedge sys_clk) if (fifoWrite) got.push_back(fifoData);
  // One frame; between lines the data bus shows the inverse so stale words never match
  task automatic frame(input logic [63:0] w, input int nl, input int nw);
    frameStart <= 1'b1;
    repeat (3) @(posedge sys_clk);
    for (int l = 0; l < nl; l++)
    begin
      lineStart <= 1'b1;
      repeat (2) @(posedge sys_clk);
      for (int k = 0; k < nw; k++)
      begin
        camData <= w;
        camValid <= 1'b1;
        @(posedge sys_clk);
      end
      camData <= ~w;
      camValid <= 1'b0;
      lineStart <= 1'b0;
      repeat (4) @(posedge sys_clk);
    end
    frameStart <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
endmodule // ppd_cam_model

// ===== bench/ppd_pixel_pipe_tb.sv
// Self-checking bench for the pixel pipeline
`timescale 1ns/1ps
`include "ppd_consts.svh"
module ppd_pixel_pipe_tb;
  localparam logic [4:0] FMT = 5'h0B; // Arbitrary format code
  logic sys_clk, resetn, camValid, lineStart, frameStart, fifoWrite;
  logic [63:0] camData, fifoData;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;
  ppd_pixel_pipe #(.FORMAT_CODE(FMT), .TAPS(2)) u_ppd_pixel_pipe
    (.sys_clk, .resetn, .camData, .camValid, .lineStart, .frameStart, .fifoData, .fifoWrite,
     .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
     .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
     .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  ppd_cam_model u_ppd_cam_model
    (.sys_clk, .camData, .camValid, .lineStart, .frameStart, .fifoData, .fifoWrite);
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic cmp(input string nm, input logic [63:0] e, input logic [63:0] g);
    checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic axiWr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    cmp("bresp", 64'h0, 64'(s_axi_bresp));
    // One edge passes so a following call never reassigns bready in this step
    @(posedge sys_clk);
  endtask
  task automatic axiRd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    cmp("rresp", 64'(er), 64'(s_axi_rresp));
    if (er == 2'h0) cmp("rdata", 64'(e), 64'(s_axi_rdata));
    @(posedge sys_clk);
  endtask
  // Sends a frame and expects ne fifo words, all equal to e
  task automatic frameChk(input logic [63:0] w, e, input int nl, nw, ne);
    u_ppd_cam_model.got.delete();
    u_ppd_cam_model.frame(w, nl, nw);
    repeat (20) @(posedge sys_clk);
    cmp("count", 64'(ne), 64'(u_ppd_cam_model.got.size()));
    foreach (u_ppd_cam_model.got[i]) cmp("fifoData", e, u_ppd_cam_model.got[i]);
  endtask
  task automatic report_and_stop;
    $display("Mismatches %0d, checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic tReset;
    axiRd(`PPD_REG_CTRL, `PPD_CTRL_RST, 2'h0);
    axiRd(`PPD_REG_MASK, `PPD_MASK_RST, 2'h0);
    axiRd(`PPD_REG_STAT, {27'h0, FMT}, 2'h0);
    axiRd(8'h40, 32'h0, 2'h2);
  endtask
  // Second line lies outside one active line; only three clocks are active
  task automatic tWindow;
    axiWr(`PPD_REG_ACLK, 32'h3);
    axiWr(`PPD_REG_ALIN, 32'h1);
    frameChk({8{8'h5A}}, {8{8'h5A}}, 2, 5, 3);
    axiWr(`PPD_REG_ACLK, 32'h8);
  endtask
  task automatic tMask;
    axiWr(`PPD_REG_MASK, 32'hF0F0_F0F0);
    frameChk({8{8'hFF}}, {8{8'hF0}}, 1, 2, 2);
    axiWr(`PPD_REG_MASK, `PPD_MASK_RST);
  endtask
  // Uniform bytes keep the result independent of lane order
  task automatic tClip;
    logic [7:0] vin[5] = '{8'hFA, 8'h05, 8'hF5, 8'h0A, 8'h80};
    logic [7:0] vout[5] = '{8'hF5, 8'h0A, 8'hF5, 8'h0A, 8'h80};
    axiWr(`PPD_REG_CTRL, 32'h0000_0400);
    foreach (vin[i]) frameChk({8{vin[i]}}, {8{vout[i]}}, 1, 2, 2);
    axiWr(`PPD_REG_CTRL, 32'h0);
  endtask
  task automatic tShift;
    axiWr(`PPD_REG_CTRL, 32'h0000_0014);
    frameChk({4{16'hF0F0}}, {4{16'h0F0F}}, 1, 2, 2);
    axiWr(`PPD_REG_CTRL, 32'h0000_0004);
    frameChk({4{16'h0F0F}}, {4{16'hF0F0}}, 1, 2, 2);
    axiWr(`PPD_REG_CTRL, 32'h0);
  endtask
  // Longest delay; a flag that lagged its data would let the inverted gap word in
  task automatic tDelay;
    axiWr(`PPD_REG_CTRL, 32'h0000_0100);
    frameChk(64'h3C3C_A5A5_0F0F_7E7E, 64'h3C3C_A5A5_0F0F_7E7E, 1, 2, 2);
    axiWr(`PPD_REG_CTRL, 32'h0);
  endtask
  task automatic tSwap;
    axiWr(`PPD_REG_CTRL, 32'h0000_0800);
    frameChk(64'h0123_4567_89AB_CDEF, 64'h89AB_CDEF_0123_4567, 1, 2, 2);
    axiWr(`PPD_REG_CTRL, 32'h0);
  endtask
  // Ten-bit pixels at depth 16, shifted right by two; two beats pack one word
  task automatic tView8;
    axiWr(`PPD_REG_CTRL, 32'h0000_3012);
    frameChk({4{16'h0204}}, {8{8'h81}}, 1, 2, 1);
    axiWr(`PPD_REG_CTRL, 32'h0);
  endtask
  // Window trimmed first so the free-running pattern writes nothing outside a line
  task automatic tSynth;
    axiWr(`PPD_REG_ACLK, 32'h2);
    axiWr(`PPD_REG_CTRL, 32'h0001_0200);
    frameChk(64'h0, 64'h0706_0504_0302_0100, 1, 2, 2);
    axiWr(`PPD_REG_CTRL, 32'h0);
    axiWr(`PPD_REG_ACLK, 32'h8);
  endtask
  // ----------------------------------------
  // Clock, reset, timeout and main sequence
  // ----------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end
  initial
  begin
    {resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    tReset();
    tWindow();
    tMask();
    tClip();
    tShift();
    tDelay();
    tSwap();
    tView8();
    tSynth();
    report_and_stop();
  end
endmodule // ppd_pixel_pipe_tb
